// ===== core/epaa_core.sv
// external port asynchronous access: address, strobes, selects, data bus muxing
// assumes a core-side request port held until taken while req_ready, inputs synchronous to core_clk
// assumes ack is synchronous; a source in another clock domain needs a synchroniser first
// assumes the small-memory variant is picked by parameter, refusing 16-bit audio at load
//
// Contract
// - every external access shows its target on the 24-bit address output.
// - each data bus pin serves memory data, audio input, flag or pwm as configured.
// - after reset all pins are memory data except flags 0 to 3 which are flags.
// - the input data channel samples words from the data pins when so selected.
// - the small-memory variant never offers 16-bit audio input on the data bus.
// - a low acknowledge holds the access open until it returns high.
// - the read strobe is low for each word read and high otherwise.
// - the write strobe is low for each word written and high otherwise.
// - bank selects are decoded with the address and idle high.
// - a conditional access drives bank selects even when its condition is false.
`timescale 1ns/1ps
module epaa_core
	import epaa_pkg::*;
#(
	parameter int  WIDTH       = DATA_W,
	parameter int  AW          = ADDR_W,
	parameter int  NBANK       = BANKS,
	parameter bit  SMALL_MEM   = 1'b0,
	parameter int  STROBE_MIN  = STROBE_CYC
) (
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	// core request port
	input  wire logic                 req_valid,
	input  wire logic                 req_write,
	input  wire logic                 req_cond_true,
	input  wire logic [AW-1:0]        req_addr,
	input  wire logic [$clog2(NBANK)-1:0] req_bank,
	input  wire logic [WIDTH-1:0]     req_wdata,
	output logic                      req_ready,
	output logic                      resp_valid,
	output logic [WIDTH-1:0]          resp_rdata,
	// configuration
	input  wire logic                 cfg_load,
	input  wire logic [2*WIDTH-1:0]   cfg_pin_fn,
	input  wire logic                 cfg_audio_en,
	input  wire logic                 cfg_audio_width,
	input  wire logic [WIDTH-1:0]     flag_out,
	input  wire logic [WIDTH-1:0]     flag_drive,
	input  wire logic [WIDTH-1:0]     pwm_out,
	output logic [WIDTH-1:0]          flag_in,
	output logic                      audio_valid,
	output logic [WIDTH-1:0]          audio_word,
	// pins
	output logic [AW-1:0]             addr,
	output logic                      rd_n,
	output logic                      wr_n,
	output logic [NBANK-1:0]          bank_select_n,
	input  wire logic                 ack,
	input  wire logic [WIDTH-1:0]     data_in,
	output logic [WIDTH-1:0]          data_out,
	output logic [WIDTH-1:0]          data_oe_n
);
	// pin functions after reset: flags on the lowest pins
	function automatic logic [2*WIDTH-1:0] reset_fn();
		logic [2*WIDTH-1:0] v;
		v = '0;
		for (int k = 0; k < FLAG_PINS; k++) begin
			v[2*k +: 2] = FN_FLAG;
		end
		return v;
	endfunction : reset_fn

	epaa_state_t          state;
	epaa_state_t          next_state;
	logic [2*WIDTH-1:0]   pin_fn;
	logic                 audio_en;
	logic                 audio_width;
	logic                 is_write;
	logic                 do_strobe;
	logic [WIDTH-1:0]     wdata;
	logic [7:0]           strobe_cnt;
	wire                  strobe_met = (strobe_cnt >= 8'(STROBE_MIN));
	wire                  width_ok   = !(SMALL_MEM && cfg_audio_width == AUDIO_W16);

	// decoded sequencer conditions and selections
	wire                  take         = (state == EPAA_IDLE) && req_valid;
	wire                  in_strobe    = (state == EPAA_STROBE);
	wire                  strobe_on    = (next_state == EPAA_STROBE);
	wire                  strobe_end   = in_strobe && (next_state == EPAA_DONE);
	wire                  read_end     = strobe_end && !is_write;
	wire                  access_end   = (state == EPAA_DONE);
	wire                  loaded_width = width_ok ? cfg_audio_width : AUDIO_W20;
	wire [7:0]            cnt_step     = strobe_met ? strobe_cnt : strobe_cnt + 8'h01;
	wire [NBANK-1:0]      sel_decode   = ~(NBANK'(1) << req_bank);

	// configuration, loaded with its reset defaults
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pin_fn      <= reset_fn();
			audio_en    <= 1'b0;
			audio_width <= AUDIO_W20;
		end else if (cfg_load) begin
			pin_fn      <= cfg_pin_fn;
			audio_en    <= cfg_audio_en;
			audio_width <= loaded_width;
		end
	end

	// access sequencer: idle, setup (address settles), strobe (stretched by low ack), done
	// a false condition skips the strobe but still walks the selects through setup and done
	always_comb begin
		next_state = state;
		unique case (state)
			EPAA_IDLE:   if (req_valid) next_state = EPAA_SETUP;
			EPAA_SETUP:  next_state = do_strobe ? EPAA_STROBE : EPAA_DONE;
			EPAA_STROBE: if (strobe_met && ack) next_state = EPAA_DONE;
			EPAA_DONE:   next_state = EPAA_IDLE;
		endcase
	end

	// a new request is taken only while idle, so accesses never overlap
	assign req_ready = (state == EPAA_IDLE);

	// sequencer state
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state <= EPAA_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// address, selects and the captured request, held for the whole access
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			addr          <= '0;
			bank_select_n <= '1;
			is_write      <= 1'b0;
			do_strobe     <= 1'b0;
			wdata         <= '0;
		end else if (take) begin
			addr          <= req_addr;
			bank_select_n <= sel_decode; // selects move with the address
			is_write      <= req_write;
			do_strobe     <= req_cond_true; // false condition: selects only
			wdata         <= req_wdata;
		end else if (access_end) begin
			bank_select_n <= '1; // released once the access ends
		end
	end

	// strobes: low only in the strobe state, never both at once
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rd_n <= 1'b1;
			wr_n <= 1'b1;
		end else begin
			rd_n <= !(strobe_on && !is_write);
			wr_n <= !(strobe_on && is_write);
		end
	end

	// strobe width counter, saturating so a long wait cannot wrap it
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			strobe_cnt <= '0;
		end else if (strobe_on) begin
			strobe_cnt <= in_strobe ? cnt_step : 8'h01;
		end else begin
			strobe_cnt <= '0;
		end
	end

	// read data taken at the edge that ends the strobe, response pulse at the edge that ends done
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			resp_valid <= 1'b0;
			resp_rdata <= '0;
		end else begin
			resp_valid <= access_end;
			if (read_end) begin
				resp_rdata <= data_in;
			end
		end
	end

	// flag inputs follow the pins every cycle
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			flag_in <= '0;
		end else begin
			flag_in <= data_in;
		end
	end

	// parallel audio sampling on the input data channel
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			audio_valid <= 1'b0;
			audio_word  <= '0;
		end else begin
			audio_valid <= audio_en;
			if (audio_en) begin
				audio_word <= (audio_width == AUDIO_W16) ?
					{{(WIDTH-16){1'b0}}, data_in[15:0]} : data_in;
			end
		end
	end

	// memory data drives only during a write strobe
	wire mem_drive = !wr_n;

	epaa_pinmux #(
		.WIDTH (WIDTH)
	) u_pinmux (
		.pin_fn     (pin_fn),
		.mem_out    (wdata),
		.mem_drive  (mem_drive),
		.flag_out   (flag_out),
		.flag_drive (flag_drive),
		.pwm_out    (pwm_out),
		.pin_out    (data_out),
		.pin_oe_n   (data_oe_n)
	);
endmodule : epaa_core

// ===== core/epaa_pkg.sv
// package for the external port asynchronous access block
// assumes a single core clock domain at 10 MHz
package epaa_pkg;
	localparam int ADDR_W      = 24;
	localparam int DATA_W      = 32;
	localparam int BANKS       = 2;
	localparam int FLAG_PINS   = 4;
	localparam int CLK_NS      = 100;
	// least strobe time in ns and its cycle count (rounded up, at least one)
	localparam int STROBE_NS   = 100;
	localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	// pin function codes, two bits per pin
	localparam logic [1:0] FN_MEM   = 2'h0;
	localparam logic [1:0] FN_AUDIO = 2'h1;
	localparam logic [1:0] FN_FLAG  = 2'h2;
	localparam logic [1:0] FN_PWM   = 2'h3;
	// audio input widths
	localparam logic AUDIO_W20 = 1'h0;
	localparam logic AUDIO_W16 = 1'h1;
	typedef enum logic [1:0] {
		EPAA_IDLE   = 2'b00,
		EPAA_SETUP  = 2'b01,
		EPAA_STROBE = 2'b11,
		EPAA_DONE   = 2'b10
	} epaa_state_t;
endpackage : epaa_pkg

// ===== core/epaa_pinmux.sv
// per-pin function selection for the external data bus
// assumes function codes are held stable by the caller
`timescale 1ns/1ps
module epaa_pinmux
	import epaa_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	input  wire logic [2*WIDTH-1:0] pin_fn,
	input  wire logic [WIDTH-1:0]   mem_out,
	input  wire logic               mem_drive,
	input  wire logic [WIDTH-1:0]   flag_out,
	input  wire logic [WIDTH-1:0]   flag_drive,
	input  wire logic [WIDTH-1:0]   pwm_out,
	output logic      [WIDTH-1:0]   pin_out,
	output logic      [WIDTH-1:0]   pin_oe_n
);
	// each pin chooses its source by its own code
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_pin
			wire [1:0] fn = pin_fn[2*i +: 2];
			assign pin_out[i]  = (fn == FN_FLAG) ? flag_out[i] :
				(fn == FN_PWM) ? pwm_out[i] : mem_out[i];
			assign pin_oe_n[i] = (fn == FN_MEM)  ? ~mem_drive :
				(fn == FN_FLAG) ? ~flag_drive[i] :
				(fn == FN_PWM)  ? 1'b0 : 1'b1; // audio pins only listen
		end
	endgenerate
endmodule : epaa_pinmux

// ===== verification/epaa_core_chk.sv
// checker: timing of address, strobes and selects
// assumes default parameters of the access block
`timescale 1ns/1ps
module epaa_core_chk (
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic        req_write,
	input wire logic        req_cond_true,
	input wire logic [23:0] req_addr,
	input wire logic [0:0]  req_bank,
	input wire logic        resp_valid,
	input wire logic [23:0] addr,
	input wire logic        rd_n,
	input wire logic        wr_n,
	input wire logic [1:0]  bank_select_n,
	input wire logic        ack
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// request taken at this edge
	wire take = req_valid && req_ready;
	property p_addr; take |=> addr == $past(req_addr); endproperty
	a_addr: assert property (p_addr) else $error("address wrong");
	property p_sel; take |=> bank_select_n == ~(2'h1 << $past(req_bank)); endproperty
	a_sel: assert property (p_sel) else $error("select wrong");
	property p_rd; take && !req_write && req_cond_true |-> ##2 !rd_n && wr_n; endproperty
	a_rd: assert property (p_rd) else $error("read strobe");
	property p_wr; take && req_write && req_cond_true |-> ##2 !wr_n && rd_n; endproperty
	a_wr: assert property (p_wr) else $error("write strobe");
	property p_cond; take && !req_cond_true |=> (bank_select_n != 2'h3 && rd_n && wr_n) [*2];
	endproperty
	a_cond: assert property (p_cond) else $error("false cond");
	property p_ack; !ack && !(rd_n && wr_n) |=> $stable({rd_n, wr_n}); endproperty
	a_ack: assert property (p_ack) else $error("wait ignored");
	property p_excl; rd_n || wr_n; endproperty
	a_excl: assert property (p_excl) else $error("strobes overlap");
	property p_end; take |-> ##[3:40] resp_valid; endproperty
	a_end: assert property (p_end) else $error("no completion");
	property p_idle; resp_valid |-> bank_select_n == 2'h3; endproperty
	a_idle: assert property (p_idle) else $error("select not idle");
endmodule : epaa_core_chk
bind epaa_core epaa_core_chk u_chk (.core_clk, .reset, .req_valid, .req_ready, .req_write,
	.req_cond_true, .req_addr, .req_bank, .resp_valid, .addr, .rd_n, .wr_n, .bank_select_n, .ack);

// ===== verification/epaa_mem_model.sv
// far side: memory with wait states on a pulled-up bus
// assumes the bench drives the audio source on ext
`timescale 1ns/1ps
module epaa_mem_model (
	input wire logic        core_clk,
	input wire logic        rd_n,
	input wire logic        wr_n,
	input wire logic [23:0] addr,
	input wire logic [31:0] data_out,
	input wire logic [31:0] data_oe_n,
	input wire logic [31:0] ext,
	input wire logic [3:0]  waits,
	output logic            ack,
	output logic [31:0]     bus
);
	logic [31:0] mem [16];
	logic [3:0]  cnt = 4'h0;
	// ack low for the first strobe cycles, pulled high otherwise
	assign ack = (rd_n && wr_n) || cnt >= waits;
	assign bus = (~data_oe_n & data_out) | (data_oe_n & (!rd_n ? mem[addr[3:0]] : ext));
	// count strobe cycles, store at the end of a write
	always @(posedge core_clk) begin
		cnt <= (rd_n && wr_n) ? 4'h0 : cnt + 4'h1;
		if (!wr_n && ack)
			mem[addr[3:0]] <= bus;
	end
endmodule : epaa_mem_model

// ===== verification/external_port_async_access_bench.sv
// bench: accesses against the memory model
// assumes default parameters, 100 ns clock
`timescale 1ns/1ps
module external_port_async_access_bench;
	typedef struct {logic w; logic [23:0] a; logic [31:0] d; logic [3:0] wt;} epaa_row_t;
	epaa_row_t rows [4] = '{'{1, 24'hfffff2, 32'h89abcdef, 4'h0}, '{1, 24'h000005, 32'h0, 4'h2},
		'{0, 24'hfffff2, 32'h89abcdef, 4'h1}, '{0, 24'h000005, 32'h0, 4'h0}};
	logic core_clk = 0, reset = 1, req_valid = 0, req_write = 0, req_cond_true = 1, cfg_load = 0;
	logic cfg_audio_en = 0, req_ready, resp_valid, audio_valid, rd_n, wr_n, ack;
	logic cfg_audio_width = 0;
	logic [0:0] req_bank = 0;
	logic [1:0] bank_select_n;
	logic [3:0] waits = 0;
	logic [23:0] req_addr = 0, addr;
	logic [63:0] cfg_pin_fn = 0;
	logic [31:0] req_wdata = 0, flag_out = 32'ha, flag_drive = '1, pwm_out = 32'h5a5a5a5a;
	logic [31:0] ext = '1, resp_rdata, flag_in, audio_word, data_out, data_oe_n, bus;
	logic [31:0] small_word;
	int miscompares = 0, check_count = 0;
	epaa_core uut (.core_clk, .reset, .req_valid, .req_write, .req_cond_true, .req_addr,
		.req_bank, .req_wdata, .req_ready, .resp_valid, .resp_rdata, .cfg_load, .cfg_pin_fn,
		.cfg_audio_en, .cfg_audio_width, .flag_out, .flag_drive, .pwm_out, .flag_in,
		.audio_valid, .audio_word, .addr, .rd_n, .wr_n, .bank_select_n, .ack,
		.data_in(bus), .data_out, .data_oe_n);
	// small-memory variant beside it, watched only for its audio width
	epaa_core #(.SMALL_MEM(1'b1)) uut_small (.core_clk, .reset, .req_valid, .req_write,
		.req_cond_true, .req_addr, .req_bank, .req_wdata, .req_ready(), .resp_valid(),
		.resp_rdata(), .cfg_load, .cfg_pin_fn, .cfg_audio_en, .cfg_audio_width, .flag_out,
		.flag_drive, .pwm_out, .flag_in(), .audio_valid(), .audio_word(small_word), .addr(),
		.rd_n(), .wr_n(), .bank_select_n(), .ack, .data_in(bus), .data_out(), .data_oe_n());
	epaa_mem_model u_mem (.core_clk, .rd_n, .wr_n, .addr, .data_out, .data_oe_n, .ext, .waits,
		.ack, .bus);
	task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one access, counting cycles until completion
	task automatic acc(logic w, logic c, logic [23:0] a, logic [31:0] d, logic [3:0] wt);
		int n;
		n = 0;
		chk("ready", req_ready, 1);
		{req_valid, req_write, req_cond_true, req_addr, req_bank, req_wdata} = {1'b1, w, c, a, a[0], d};
		waits = wt;
		do begin
			@(negedge core_clk);
			req_valid = 0;
			n++;
		end while (resp_valid !== 1'b1 && n < 40);
		chk("latency", n, c ? 3 + epaa_pkg::STROBE_CYC + wt : 3);
	endtask : acc
	task automatic summarize();
		$display("comparisons %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	initial forever #50 core_clk = ~core_clk;
	initial begin
		#100000;
		miscompares++;
		summarize();
	end
	// reset state, pin functions, access rows, then awkward cases
	initial begin
		repeat (5) @(negedge core_clk);
		chk("reset oe", data_oe_n, 32'hfffffff0);
		chk("reset pins", {addr, rd_n, wr_n, bank_select_n}, {24'h0, 4'hf});
		reset = 0;
		for (int k = 3; k >= 0; k--) begin
			{cfg_pin_fn, cfg_audio_en, ext, cfg_load} = {{32{k[1:0]}}, k == 1, 32'h1234abcd, 1'b1};
			@(negedge core_clk);
			cfg_load = 0;
			repeat (3) @(negedge core_clk);
			chk("oe", data_oe_n, k > 1 ? 32'h0 : 32'hffffffff);
			if (k == 3) chk("pwm", data_out, pwm_out);
			if (k == 2) chk("flag", {data_out, flag_in}, {flag_out, flag_out});
			if (k == 1) chk("audio", {audio_valid, audio_word}, {1'b1, ext});
		end
		{cfg_pin_fn, cfg_audio_en, cfg_audio_width, cfg_load} = {{32{2'h1}}, 3'h7};
		@(negedge core_clk);
		cfg_load = 0;
		repeat (2) @(negedge core_clk);
		chk("audio16", {audio_word, small_word}, {32'h0000abcd, ext});
		{cfg_pin_fn, cfg_audio_en, cfg_audio_width, cfg_load} = {64'h0, 3'h1};
		@(negedge core_clk);
		cfg_load = 0;
		ext = '1;
		foreach (rows[i]) begin
			acc(rows[i].w, 1, rows[i].a, rows[i].d, rows[i].wt);
			if (!rows[i].w) chk("rdata", resp_rdata, rows[i].d);
		end
		acc(1, 0, 24'hfffff2, 32'h0, 4'h0);
		acc(0, 1, 24'hfffff2, 32'h0, 4'h0);
		chk("no write", resp_rdata, 32'h89abcdef);
		reset = 1;
		@(negedge core_clk);
		chk("reset again", {data_oe_n, resp_rdata}, {32'hfffffff0, 32'h0});
		reset = 0;
		@(negedge core_clk);
		chk("idle after reset", {req_ready, rd_n, wr_n, bank_select_n}, 5'h1f);
		summarize();
	end
endmodule : external_port_async_access_bench
